/* File: core/sfe_pkg.sv */
/*
 Shared constants and types for the serial flash erase link: opcodes,
 wipe timing, address layout and the controller's register map.
 Assumes a 200 MHz aclk in both ends.
*/
package sfe_pkg;
	// ----------------------------------------------------------------
	// Clock, array and opcodes
	// ----------------------------------------------------------------
	localparam int          CLK_NS       = 5;
	localparam int          ADDR_W       = 25;
	localparam logic [7:0]  OP_UNLOCK    = 8'ha1;
	localparam logic [7:0]  OP_WIPE_4K   = 8'ha2;
	localparam logic [7:0]  OP_WIPE_32K  = 8'ha3;
	localparam logic [7:0]  OP_WIPE_64K  = 8'ha4;
	localparam logic [7:0]  OP_WIPE_ALL  = 8'ha5;
	localparam logic [7:0]  OP_STATUS    = 8'ha6;
	localparam logic [5:0]  OP_BITS      = 6'h08;
	localparam logic [5:0]  ADDR3_BITS   = 6'h18;
	localparam logic [5:0]  ADDR4_BITS   = 6'h20;
	localparam int          SECTOR_LSB   = 12;
	localparam int          B32_LSB      = 15;
	localparam int          B64_LSB      = 16;
	localparam int          ST_BUSY      = 0;
	localparam int          ST_UNLOCK    = 1;
	// ----------------------------------------------------------------
	// Self-timed wipe durations
	// ----------------------------------------------------------------
	localparam int          SECTOR_WIPE_NS = 2000;
	localparam int          WIPE_32K_NS    = 4000;
	localparam int          WIPE_64K_NS    = 6000;
	localparam int          ARRAY_WIPE_NS  = 10000;
	localparam logic [15:0] SECTOR_WIPE_CYC =
		16'((SECTOR_WIPE_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [15:0] WIPE_32K_CYC =
		16'((WIPE_32K_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [15:0] WIPE_64K_CYC =
		16'((WIPE_64K_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [15:0] ARRAY_WIPE_CYC =
		16'((ARRAY_WIPE_NS + CLK_NS - 1) / CLK_NS);
	// ----------------------------------------------------------------
	// Controller registers and link timing
	// ----------------------------------------------------------------
	localparam logic [7:0]  REG_CMD      = 8'h00;
	localparam logic [7:0]  REG_ADDR     = 8'h04;
	localparam logic [7:0]  REG_STAT     = 8'h08;
	localparam logic [31:0] RST_CMD      = 32'h0;
	localparam logic [31:0] RST_ADDR     = 32'h0;
	localparam int          CMD_ADDR_BIT = 8;
	localparam int          CMD_READ_BIT = 9;
	localparam int          CMD_QUAD_BIT = 10;
	localparam int          CMD_A4_BIT   = 11;
	localparam logic [5:0]  SCLK_HALF    = 6'h10;
	localparam logic [1:0]  RESP_OKAY    = 2'h0;
	localparam logic [1:0]  RESP_DECERR  = 2'h3;

	typedef enum logic [1:0] {
		SFE_K4K  = 2'b00,
		SFE_K32K = 2'b01,
		SFE_K64K = 2'b10,
		SFE_KALL = 2'b11
	} sfe_kind_t;

	typedef enum logic {
		D_IDLE = 1'b0,
		D_BUSY = 1'b1
	} sfe_dstate_t;

	typedef enum logic [1:0] {
		H_IDLE = 2'b00,
		H_LOW  = 2'b01,
		H_HIGH = 2'b10,
		H_END  = 2'b11
	} sfe_hstate_t;
endpackage : sfe_pkg

/* File: core/sfe_link_if.sv */
/*
 Link between the flash controller and the flash device: select, clock
 and four two-way data lines. Each two-way line is resolved here from
 both enables; an undriven line floats high as with a pull-up.
*/
`timescale 1ns/1ps
interface sfe_link_if;
	logic       cs_n;
	logic       sclk;
	logic [3:0] h_io_o;
	logic [3:0] h_io_oe_n;
	logic [3:0] d_io_o;
	logic [3:0] d_io_oe_n;
	logic [3:0] io;

	// ----------------------------------------------------------------
	// Wire resolution, host first
	// ----------------------------------------------------------------
	assign io = (~h_io_oe_n & h_io_o) | (~d_io_oe_n & h_io_oe_n & d_io_o)
		| (h_io_oe_n & d_io_oe_n);

	modport host (output cs_n, output sclk, output h_io_o,
		output h_io_oe_n, input io);
	modport dev (input cs_n, input sclk, input io, output d_io_o,
		output d_io_oe_n);
endinterface : sfe_link_if

/* File: core/sfe_device.sv */
/*
 Flash device end: erase command decoder with self-timed wipe sequencer,
 busy flag, write-unlock latch and status read-out.
 Assumes the link pins are asynchronous to aclk and that the array
 itself sits outside and acts on the wipe_* request.
*/
// Functional notes
// - Sector wipe request covers whole 4K sector
// - Wipes act only with unlock latch set
// - Select rise off address end rejects command
// - Sector chosen by address bits twelve upward
// - Three-byte default; four-byte or bank bit
// - Host sends opcode, address, then raises select
// - Eight serial or two quad clocks
// - Sector wipe timed; busy then both clear
// - Status reads answered while wiping
// - Protected sector wipe is not performed
// - 32K block chosen by bits fifteen upward
// - Any address inside 32K block accepted
// - 32K wipe busy timed, then both clear
// - Protected 32K block wipe skipped
// - 64K block wiped, any inside address
// - 64K wipe timed, clears, skips protected
// - Chip wipe is opcode alone
// - Chip wipe timed; busy then both clear
// - Range-lock scheme: any lock refuses chip
// - Sector-lock scheme: chip skips locked blocks
`timescale 1ns/1ps
module sfe_device (
	input  wire logic                      aclk,
	input  wire logic                      aresetn,
	sfe_link_if.dev                        link,
	input  wire logic                      quad_cmd_protocol,
	input  wire logic                      four_byte_mode,
	input  wire logic                      high_addr_bank_bit,
	input  wire logic [3:0]                range_lock_bits,
	input  wire logic                      lock_scheme_select,
	input  wire logic [15:0]               per_sector_lock_bits,
	output logic                           busy_flag,
	output logic                           write_unlock_latch,
	output logic                           wipe_start,
	output sfe_pkg::sfe_kind_t             wipe_kind,
	output logic [sfe_pkg::ADDR_W-1:0]     wipe_addr,
	output logic [15:0]                    wipe_skip_mask,
	output logic                           cmd_rejected
);
	import sfe_pkg::*;

	// ----------------------------------------------------------------
	// Pin synchronisers and edge detection
	// ----------------------------------------------------------------
	logic [5:0]         meta_reg;
	logic [5:0]         sync_reg;
	logic               cs_d_reg;
	logic               sck_d_reg;
	wire                cs_s  = sync_reg[5];
	wire                sck_s = sync_reg[4];
	wire  [3:0]         io_s  = sync_reg[3:0];
	wire                sck_rise = sck_s & ~sck_d_reg & ~cs_s;
	wire                sck_fall = ~sck_s & sck_d_reg & ~cs_s;
	wire                cs_rise  = cs_s & ~cs_d_reg;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			// Idle pin levels, so no false edge follows reset
			meta_reg  <= 6'h2f;
			sync_reg  <= 6'h2f;
			cs_d_reg  <= 1'b1;
			sck_d_reg <= 1'b0;
		end else begin
			meta_reg  <= {link.cs_n, link.sclk, link.io};
			sync_reg  <= meta_reg;
			cs_d_reg  <= cs_s;
			sck_d_reg <= sck_s;
		end
	end

	// ----------------------------------------------------------------
	// Frame shifter
	// ----------------------------------------------------------------
	logic [39:0]        sh_reg;
	logic [5:0]         cnt_reg;
	logic [7:0]         op_reg;
	wire  [5:0]         step = quad_cmd_protocol ? 6'h04 : 6'h01;
	// Lines one to three are ignored in serial mode
	wire  [39:0]        sh_next = quad_cmd_protocol ?
		{sh_reg[35:0], io_s} : {sh_reg[38:0], io_s[0]};
	// Saturate so an overlong frame never wraps onto a boundary
	wire  [5:0]         cnt_next = (cnt_reg > 6'h38) ? cnt_reg :
		6'(cnt_reg + step);
	wire                op_done = sck_rise & (cnt_next == OP_BITS);

	always_ff @(posedge aclk) begin
		if (!aresetn || cs_s) begin
			sh_reg  <= 40'h0;
			cnt_reg <= 6'h00;
			op_reg  <= 8'h00;
		end else if (sck_rise) begin
			sh_reg  <= sh_next;
			cnt_reg <= cnt_next;
			if (op_done)
				op_reg <= sh_next[7:0];
		end
	end

	// ----------------------------------------------------------------
	// Command decode at select rise
	// ----------------------------------------------------------------
	sfe_dstate_t        state_reg;
	logic [15:0]        timer_reg;
	wire  [5:0]         addr_bits = four_byte_mode ? ADDR4_BITS : ADDR3_BITS;
	wire  [31:0]        abytes = four_byte_mode ? sh_reg[31:0] :
		{7'h00, high_addr_bank_bit, sh_reg[23:0]};
	wire  [ADDR_W-1:0]  tgt = abytes[ADDR_W-1:0];
	wire                at_addr_end = cnt_reg == 6'(OP_BITS + addr_bits);
	wire                at_op_end = cnt_reg == OP_BITS;
	wire                op_4k  = op_reg == OP_WIPE_4K;
	wire                op_32k = op_reg == OP_WIPE_32K;
	wire                op_64k = op_reg == OP_WIPE_64K;
	wire                op_all = op_reg == OP_WIPE_ALL;
	wire                op_addr = op_4k | op_32k | op_64k;
	wire                idle = state_reg == D_IDLE;
	wire  [8:0]         blk = tgt[ADDR_W-1:B64_LSB];
	wire  [15:0]        top_dist = {7'h00, ~blk};
	// Range locks guard the top 2^(n-1) 64K blocks
	wire                range_hit = (range_lock_bits != 4'h0) &&
		(top_dist < (16'h0001 << (range_lock_bits - 4'h1)));
	wire                sect_hit = per_sector_lock_bits[blk[3:0]];
	wire                prot = lock_scheme_select ? sect_hit :
		range_hit;
	wire                all_locked = ~lock_scheme_select &
		(range_lock_bits != 4'h0);
	wire                go_addr = cs_rise & op_addr & at_addr_end &
		write_unlock_latch & idle & ~prot;
	wire                go_all = cs_rise & op_all & at_op_end &
		write_unlock_latch & idle & ~all_locked;
	wire                go = go_addr | go_all;
	wire                do_unlock = cs_rise & (op_reg == OP_UNLOCK) &
		at_op_end & idle;
	wire                refuse = cs_rise & (op_addr | op_all) &
		~go;

	sfe_kind_t          kind;
	logic [ADDR_W-1:0]  amask;
	logic [15:0]        cyc;
	always_comb begin
		kind  = SFE_KALL;
		amask = '0;
		cyc   = ARRAY_WIPE_CYC;
		if (op_4k) begin
			kind  = SFE_K4K;
			amask = ~ADDR_W'((1 << SECTOR_LSB) - 1);
			cyc   = SECTOR_WIPE_CYC;
		end else if (op_32k) begin
			kind  = SFE_K32K;
			amask = ~ADDR_W'((1 << B32_LSB) - 1);
			cyc   = WIPE_32K_CYC;
		end else if (op_64k) begin
			kind  = SFE_K64K;
			amask = ~ADDR_W'((1 << B64_LSB) - 1);
			cyc   = WIPE_64K_CYC;
		end
	end

	// ----------------------------------------------------------------
	// Self-timed wipe sequencer
	// ----------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_reg          <= D_IDLE;
			timer_reg          <= 16'h0000;
			write_unlock_latch <= 1'b0;
		end else begin
			case (state_reg)
			D_IDLE: begin
				if (do_unlock)
					write_unlock_latch <= 1'b1;
				if (go) begin
					state_reg <= D_BUSY;
					timer_reg <= 16'(cyc - 16'h0001);
				end
			end
			D_BUSY: begin
				if (timer_reg == 16'h0000) begin
					state_reg          <= D_IDLE;
					write_unlock_latch <= 1'b0;
				end else begin
					timer_reg <= 16'(timer_reg - 16'h0001);
				end
			end
			default: state_reg <= D_IDLE;
			endcase
		end
	end

	assign busy_flag = state_reg == D_BUSY;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wipe_start     <= 1'b0;
			wipe_kind      <= SFE_K4K;
			wipe_addr      <= '0;
			wipe_skip_mask <= 16'h0000;
			cmd_rejected   <= 1'b0;
		end else begin
			wipe_start   <= go;
			cmd_rejected <= refuse;
			if (go) begin
				wipe_kind      <= kind;
				wipe_addr      <= tgt & amask;
				wipe_skip_mask <= (op_all & lock_scheme_select) ?
					per_sector_lock_bits : 16'h0000;
			end
		end
	end

	// ----------------------------------------------------------------
	// Status read-out, served even while busy
	// ----------------------------------------------------------------
	logic [7:0]         sout_reg;
	logic [3:0]         io_o_reg;
	logic [3:0]         io_oe_n_reg;
	wire  [7:0]         status = {6'h00, write_unlock_latch, busy_flag};
	wire                rd_act = (op_reg == OP_STATUS) & (cnt_reg >= OP_BITS);

	always_ff @(posedge aclk) begin
		if (!aresetn || cs_s) begin
			sout_reg    <= 8'h00;
			io_o_reg    <= 4'h0;
			io_oe_n_reg <= 4'hf;
		end else if (op_done && sh_next[7:0] == OP_STATUS) begin
			sout_reg <= status;
		end else if (sck_fall && rd_act) begin
			// Byte rotates so a long read repeats it
			if (quad_cmd_protocol) begin
				io_o_reg    <= sout_reg[7:4];
				io_oe_n_reg <= 4'h0;
				sout_reg    <= {sout_reg[3:0], sout_reg[7:4]};
			end else begin
				io_o_reg    <= {2'b00, sout_reg[7], 1'b0};
				io_oe_n_reg <= 4'b1101;
				sout_reg    <= {sout_reg[6:0], sout_reg[7]};
			end
		end
	end

	assign link.d_io_o    = io_o_reg;
	assign link.d_io_oe_n = io_oe_n_reg;
endmodule : sfe_device

/* File: core/sfe_host.sv */
/*
 Flash controller end: AXI4-Lite register slave that runs one link
 frame per command write, serial or quad, with optional status read.
 Assumes software leaves the link idle before issuing a new command.
*/
// Added by the designer: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/1ps
module sfe_host (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	sfe_link_if.host         link
);
	import sfe_pkg::*;

	// ----------------------------------------------------------------
	// Register slave
	// ----------------------------------------------------------------
	logic [7:0]  awaddr_reg;
	logic [31:0] wdata_reg;
	logic [3:0]  wstrb_reg;
	logic [31:0] cmd_reg;
	logic [31:0] addr_reg;
	logic [7:0]  rx_reg;
	logic        start_reg;
	sfe_hstate_t state_reg;
	wire         both = ~s_axi_awready & ~s_axi_wready & ~s_axi_bvalid;
	wire         hit_cmd  = awaddr_reg == REG_CMD;
	wire         hit_addr = awaddr_reg == REG_ADDR;
	wire         hit_w = hit_cmd | hit_addr | (awaddr_reg == REG_STAT);
	wire         hit_r = (s_axi_araddr == REG_CMD) |
		(s_axi_araddr == REG_ADDR) | (s_axi_araddr == REG_STAT);
	wire         idle = state_reg == H_IDLE;
	wire [31:0]  bmask = {{8{wstrb_reg[3]}}, {8{wstrb_reg[2]}},
		{8{wstrb_reg[1]}}, {8{wstrb_reg[0]}}};
	wire [31:0]  rmux = (s_axi_araddr == REG_CMD) ? cmd_reg :
		(s_axi_araddr == REG_ADDR) ? addr_reg :
		(s_axi_araddr == REG_STAT) ? {16'h0000, rx_reg, 7'h00, ~idle} :
		32'h0;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b1;
			s_axi_wready  <= 1'b1;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= RESP_OKAY;
			awaddr_reg    <= 8'h00;
			wdata_reg     <= 32'h0;
			wstrb_reg     <= 4'h0;
			cmd_reg       <= RST_CMD;
			addr_reg      <= RST_ADDR;
			start_reg     <= 1'b0;
		end else begin
			start_reg <= 1'b0;
			if (s_axi_awvalid && s_axi_awready) begin
				awaddr_reg    <= s_axi_awaddr;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				wdata_reg    <= s_axi_wdata;
				wstrb_reg    <= s_axi_wstrb;
				s_axi_wready <= 1'b0;
			end
			if (both) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= hit_w ? RESP_OKAY : RESP_DECERR;
				// A command written mid-frame is dropped
				if (hit_cmd && idle) begin
					cmd_reg   <= (cmd_reg & ~bmask) | (wdata_reg & bmask);
					start_reg <= 1'b1;
				end
				if (hit_addr)
					addr_reg <= (addr_reg & ~bmask) | (wdata_reg & bmask);
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid  <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready  <= 1'b1;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0;
			s_axi_rresp   <= RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b1;
			s_axi_rdata   <= rmux;
			s_axi_rresp   <= hit_r ? RESP_OKAY : RESP_DECERR;
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid  <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// Link frame engine; clock made by dividing aclk
	// ----------------------------------------------------------------
	logic [3:0]  meta_reg;
	logic [3:0]  io_s_reg;
	logic [39:0] tx_reg;
	logic [5:0]  div_reg;
	logic [5:0]  left_reg;
	logic [5:0]  rdcl_reg;
	logic        cs_n_reg;
	logic        sclk_reg;
	logic [3:0]  io_o_reg;
	logic [3:0]  oe_n_reg;
	wire         quad = cmd_reg[CMD_QUAD_BIT];
	wire         a4 = cmd_reg[CMD_A4_BIT];
	wire [5:0]   cbits = 6'(OP_BITS + (~cmd_reg[CMD_ADDR_BIT] ? 6'h00 :
		(a4 ? ADDR4_BITS : ADDR3_BITS)));
	wire [5:0]   cclk = quad ? {2'b00, cbits[5:2]} : cbits;
	wire [5:0]   rclk = ~cmd_reg[CMD_READ_BIT] ? 6'h00 :
		(quad ? 6'h02 : 6'h08);
	wire [3:0]   lane_oe = quad ? 4'h0 : 4'b1110;
	wire [3:0]   lane_o = quad ? tx_reg[39:36] : {3'b000, tx_reg[39]};
	wire [39:0]  tx_sh = quad ? {tx_reg[35:0], 4'h0} : {tx_reg[38:0], 1'b0};
	wire         more_cmd = (left_reg - 6'h01) > rdcl_reg;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			meta_reg <= 4'hf;
			io_s_reg <= 4'hf;
		end else begin
			meta_reg <= link.io;
			io_s_reg <= meta_reg;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_reg <= H_IDLE;
			cs_n_reg  <= 1'b1;
			sclk_reg  <= 1'b0;
			io_o_reg  <= 4'h0;
			oe_n_reg  <= 4'hf;
			tx_reg    <= 40'h0;
			div_reg   <= 6'h00;
			left_reg  <= 6'h00;
			rdcl_reg  <= 6'h00;
			rx_reg    <= 8'h00;
		end else begin
			div_reg <= (div_reg == 6'h00) ? 6'h00 : 6'(div_reg - 6'h01);
			case (state_reg)
			H_IDLE: begin
				if (start_reg) begin
					cs_n_reg  <= 1'b0;
					tx_reg    <= {cmd_reg[7:0], a4 ? addr_reg :
						{addr_reg[23:0], 8'h00}};
					left_reg  <= 6'(cclk + rclk);
					rdcl_reg  <= rclk;
					div_reg   <= 6'(SCLK_HALF + SCLK_HALF - 6'h01);
					state_reg <= H_LOW;
				end
			end
			H_LOW: begin
				if (div_reg == SCLK_HALF) begin
					io_o_reg <= lane_o;
					oe_n_reg <= lane_oe;
					tx_reg   <= tx_sh;
				end
				if (div_reg == 6'h00) begin
					sclk_reg  <= 1'b1;
					div_reg   <= 6'(SCLK_HALF - 6'h01);
					state_reg <= H_HIGH;
					if (left_reg <= rdcl_reg)
						rx_reg <= quad ? {rx_reg[3:0], io_s_reg} :
							{rx_reg[6:0], io_s_reg[1]};
				end
			end
			H_HIGH: begin
				if (div_reg == 6'h00) begin
					sclk_reg <= 1'b0;
					left_reg <= 6'(left_reg - 6'h01);
					div_reg  <= 6'(SCLK_HALF - 6'h01);
					if (left_reg == 6'h01) begin
						state_reg <= H_END;
						oe_n_reg  <= 4'hf;
					end else begin
						if (!more_cmd)
							oe_n_reg <= 4'hf;
						if (more_cmd) begin
							io_o_reg <= lane_o;
							oe_n_reg <= lane_oe;
							tx_reg   <= tx_sh;
						end
						state_reg <= H_LOW;
						div_reg   <= 6'(SCLK_HALF - 6'h01);
					end
				end
			end
			H_END: begin
				// Select rises a half clock after the last fall, then rests a half clock
				if (div_reg == 6'h00 && !cs_n_reg) begin
					cs_n_reg <= 1'b1;
					div_reg  <= 6'(SCLK_HALF - 6'h01);
				end else if (div_reg == 6'h00) begin
					state_reg <= H_IDLE;
				end
			end
			default: state_reg <= H_IDLE;
			endcase
		end
	end

	assign link.cs_n      = cs_n_reg;
	assign link.sclk      = sclk_reg;
	assign link.h_io_o    = io_o_reg;
	assign link.h_io_oe_n = oe_n_reg;
endmodule : sfe_host

/* File: tb/sfe_checker.sv */
/*
 Concurrent checks on the erase link and the device flags.
 Assumes the bench instantiates it beside the link interface.
*/
`timescale 1ns/1ps
module sfe_checker (
	input wire logic               aclk,
	input wire logic               aresetn,
	input wire logic               cs_n,
	input wire logic               sclk,
	input wire logic [3:0]         d_io_oe_n,
	input wire logic               busy_flag,
	input wire logic               write_unlock_latch,
	input wire logic               wipe_start,
	input wire sfe_pkg::sfe_kind_t wipe_kind,
	input wire logic               cmd_rejected
);
	import sfe_pkg::*;
	// ------------------------------------------------------------
	// Busy span, two ticks loose below and one above for flop alignment
	// ------------------------------------------------------------
	logic [15:0] span_reg;
	logic [15:0] span_want;
	assign span_want = (wipe_kind == SFE_K4K) ? SECTOR_WIPE_CYC :
		(wipe_kind == SFE_K32K) ? WIPE_32K_CYC :
		(wipe_kind == SFE_K64K) ? WIPE_64K_CYC : ARRAY_WIPE_CYC;
	always_ff @(posedge aclk) begin
		if (!aresetn || wipe_start)
			span_reg <= 16'h0000;
		else if (busy_flag)
			span_reg <= span_reg + 16'h0001;
	end
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	a_start_sets_busy: assert property (wipe_start |-> busy_flag)
		else $error("wipe start without busy flag");
	a_start_needs_latch: assert property (
		wipe_start |-> write_unlock_latch)
		else $error("wipe start with unlock latch clear");
	a_busy_after_cs: assert property ($rose(busy_flag) |-> cs_n)
		else $error("busy rose while select low");
	a_end_clears_latch: assert property (
		$fell(busy_flag) |-> !write_unlock_latch)
		else $error("unlock latch left set after wipe");
	a_refused_idle: assert property (
		cmd_rejected && !busy_flag |=> !busy_flag)
		else $error("busy set after refused wipe");
	a_wipe_span: assert property ($fell(busy_flag) |->
		span_reg + 16'h0002 >= span_want && span_reg <= span_want + 16'h0001)
		else $error("wipe busy span wrong");
	a_sclk_idle_low: assert property (cs_n |-> !sclk)
		else $error("link clock active outside frame");
	a_dev_released: assert property (cs_n [*6] |-> &d_io_oe_n)
		else $error("device drives lines while deselected");
endmodule : sfe_checker

/* File: tb/serial_flash_erase_commands_tb.sv */
/*
 Self-checking bench: controller and device joined by the link.
 Assumes software-visible frames are run through the AXI registers.
*/
`timescale 1ns/1ps
module serial_flash_erase_commands_tb;
	import sfe_pkg::*;
	logic aclk, aresetn = 1'b0;
	logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
	logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
	logic s_axi_arvalid = 0, s_axi_rready = 0, s_axi_bvalid, s_axi_rvalid;
	logic s_axi_awready, s_axi_wready, s_axi_arready;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic quad = 0, a4 = 0, bank = 0, lsel = 0, busy_flag, write_unlock_latch;
	logic [3:0] rlock = 4'h0;
	logic [15:0] plock = 16'h0, wipe_skip_mask;
	logic wipe_start, cmd_rejected;
	sfe_kind_t wipe_kind;
	logic [24:0] wipe_addr;
	int err_total = 0, tests_run = 0, n_go = 0, n_rej = 0;
	sfe_link_if sfe_link_if_inst ();
	sfe_host sfe_host_inst (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(4'hf), .s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready), .link(sfe_link_if_inst.host));
	sfe_device sfe_device_inst (.aclk(aclk), .aresetn(aresetn),
		.link(sfe_link_if_inst.dev), .quad_cmd_protocol(quad),
		.four_byte_mode(a4), .high_addr_bank_bit(bank),
		.range_lock_bits(rlock), .lock_scheme_select(lsel),
		.per_sector_lock_bits(plock), .busy_flag(busy_flag),
		.write_unlock_latch(write_unlock_latch), .wipe_start(wipe_start),
		.wipe_kind(wipe_kind), .wipe_addr(wipe_addr),
		.wipe_skip_mask(wipe_skip_mask), .cmd_rejected(cmd_rejected));
	sfe_checker sfe_checker_inst (.aclk(aclk), .aresetn(aresetn),
		.cs_n(sfe_link_if_inst.cs_n), .sclk(sfe_link_if_inst.sclk),
		.d_io_oe_n(sfe_link_if_inst.d_io_oe_n), .busy_flag(busy_flag),
		.write_unlock_latch(write_unlock_latch), .wipe_start(wipe_start),
		.wipe_kind(wipe_kind), .cmd_rejected(cmd_rejected));
	initial begin
		aclk = 1'b0;
		forever #2.5 aclk = ~aclk;
	end
	always @(posedge aclk) begin
		if (cmd_rejected === 1'b1)
			n_rej <= n_rej + 1;
		if (wipe_start === 1'b1)
			n_go <= n_go + 1;
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			err_total++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task automatic axw(input logic [7:0] a, input logic [31:0] d,
		output logic [1:0] r);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_awvalid <= 1'b1;
		s_axi_wdata <= d;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wready)
				s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1);
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask : axw
	task automatic axr(input logic [7:0] a, output logic [31:0] d,
		output logic [1:0] r);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_arready)
				s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask : axr
	task automatic frame(input logic [7:0] op, input logic [31:0] a,
		input logic rd, input logic ae, output logic [7:0] b);
		logic [1:0]  r;
		logic [31:0] s;
		axw(REG_ADDR, a, r);
		axw(REG_CMD, {20'h0, a4, quad, rd, ae, op}, r);
		chk(r, RESP_OKAY);
		do
			axr(REG_STAT, s, r);
		while (s[0] !== 1'b0);
		chk(r, RESP_OKAY);
		b = s[15:8];
		repeat (10) @(posedge aclk);
	endtask : frame
	task automatic wipe(input logic [7:0] op, input logic [31:0] a,
		input logic ae, input logic ok, input logic [24:0] ea);
		logic [7:0] b;
		int         g, j;
		frame(OP_UNLOCK, 32'h0, 1'b0, 1'b0, b);
		g = n_go;
		j = n_rej;
		frame(op, a, 1'b0, ae, b);
		chk(n_go - g, ok);
		chk(n_rej - j, !ok);
		if (ok) begin
			chk(wipe_kind, op - OP_WIPE_4K);
			if (ae)
				chk(wipe_addr, ea);
			frame(OP_STATUS, 32'h0, 1'b1, 1'b0, b);
			chk(b[1:0], 2'b11);
			while (busy_flag !== 1'b0)
				@(posedge aclk);
			chk(write_unlock_latch, 1'b0);
		end else
			chk(busy_flag, 1'b0);
	endtask : wipe
	task automatic mode(input logic q, input logic f, input logic k,
		input logic s, input logic [3:0] rl, input logic [15:0] pl);
		@(posedge aclk);
		quad <= q;
		a4 <= f;
		bank <= k;
		lsel <= s;
		rlock <= rl;
		plock <= pl;
	endtask : mode
	task automatic s_unmapped;
		logic [31:0] d;
		logic [1:0]  r;
		axw(8'h0c, 32'h1, r);
		chk(r, RESP_DECERR);
		axr(8'h0c, d, r);
		chk(d, 32'h0);
		chk(r, RESP_DECERR);
		axw(REG_ADDR, 32'h00abcdef, r);
		axr(REG_ADDR, d, r);
		chk(d, 32'h00abcdef);
		chk(r, RESP_OKAY);
	endtask : s_unmapped
	task automatic s_no_unlock;
		logic [7:0] b;
		int         j;
		j = n_rej;
		frame(OP_WIPE_4K, 32'h1000, 1'b0, 1'b1, b);
		chk(n_rej - j, 1);
	endtask : s_no_unlock
	task automatic s_kinds;
		mode(1, 0, 0, 0, 4'h0, 16'h0);
		wipe(OP_WIPE_4K, 32'h123456, 1, 1, 25'h0123000);
		mode(0, 0, 1, 0, 4'h0, 16'h0);
		wipe(OP_WIPE_32K, 32'habcdef, 1, 1, 25'h1ab8000);
		mode(0, 1, 0, 0, 4'h0, 16'h0);
		wipe(OP_WIPE_64K, 32'h1feffff, 1, 1, 25'h1fe0000);
		mode(1, 0, 0, 0, 4'h0, 16'h0);
		wipe(OP_WIPE_ALL, 32'h0, 0, 1, 25'h0);
	endtask : s_kinds
	task automatic s_framing;
		wipe(OP_WIPE_4K, 32'h2000, 0, 0, 25'h0);
		wipe(OP_WIPE_ALL, 32'h2000, 1, 0, 25'h0);
	endtask : s_framing
	task automatic s_protect;
		mode(0, 0, 1, 0, 4'h1, 16'h0);
		wipe(OP_WIPE_32K, 32'hff1234, 1, 0, 25'h0);
		wipe(OP_WIPE_64K, 32'hff0000, 1, 0, 25'h0);
		wipe(OP_WIPE_ALL, 32'h0, 0, 0, 25'h0);
		mode(1, 0, 0, 1, 4'h0, 16'h0008);
		wipe(OP_WIPE_4K, 32'h35000, 1, 0, 25'h0);
		wipe(OP_WIPE_ALL, 32'h0, 0, 1, 25'h0);
		chk(wipe_skip_mask, 16'h0008);
	endtask : s_protect
	task automatic complete_run;
		$display("Checks %0d, mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : complete_run
	initial begin
		#450000;
		err_total++;
		complete_run();
	end
	initial begin
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (4) @(posedge aclk);
		s_unmapped();
		s_no_unlock();
		s_kinds();
		s_framing();
		s_protect();
		complete_run();
	end
endmodule : serial_flash_erase_commands_tb
